// ===== include/cod_pkg.sv
`default_nettype none
package cod_pkg;
	localparam logic [3:0] cod_len_w = 4'h4;
	localparam logic [7:0] cod_irq_cycles = 8'h0d;
	localparam logic [7:0] cod_boundary_extra = 8'h01;
	localparam logic [7:0] cod_page_mask = 8'hff;
	localparam int cod_flag_c = 1;
	localparam int cod_flag_z = 0;
	localparam logic [7:0] cod_ops_first = 8'h15;

	typedef enum logic [2:0] {
		cod_grp_other,
		cod_grp_branch,
		cod_grp_call,
		cod_grp_jump,
		cod_grp_return,
		cod_grp_stack,
		cod_grp_flagop,
		cod_grp_interrupt
	} cod_grp_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] cycles;
		logic [1:0] length;
		logic       upd_c;
		logic       upd_z;
		logic       known;
		cod_grp_t   group;
	} cod_info_t;

	typedef struct packed {
		logic       busy;
		logic [7:0] count;
		cod_info_t  info;
	} cod_state_t;
endpackage
`default_nettype wire

// ===== design/cod_decode.sv
`default_nettype none
module cod_decode (
	input  wire logic                clock,
	input  wire logic                rst_b,
	input  wire logic                start,
	input  wire logic [7:0]          opcode,
	input  wire logic [7:0]          pc_low,
	input  wire logic                irq_accept,
	output var  cod_pkg::cod_info_t  info,
	output logic                     busy,
	output logic                     done
);
	cod_pkg::cod_state_t st;
	cod_pkg::cod_state_t next_st;
	cod_pkg::cod_info_t  dec;
	logic [8:0]          end_addr;
	logic                take_op;
	logic [7:0]          busy_run;

	// table lookup; anything below the covered range reports not known
	always_comb begin
		dec = '{valid: 1'b1, cycles: 8'h04, length: 2'h1, upd_c: 1'b0,
			upd_z: 1'b0, known: 1'b1, group: cod_pkg::cod_grp_other};
		if (opcode[7]) begin
			dec.length = 2'h2;
			case (opcode[6:4])
				3'h0: begin
					dec.cycles = 8'h05;
					dec.group = cod_pkg::cod_grp_jump;
				end
				3'h1: begin
					dec.cycles = 8'h0b;
					dec.group = cod_pkg::cod_grp_call;
				end
				3'h6: begin
					dec.cycles = 8'h07;
					dec.group = cod_pkg::cod_grp_jump;
				end
				3'h7: begin
					dec.cycles = 8'h0d;
					dec.upd_z = 1'b1;
				end
				default: begin
					dec.cycles = 8'h05;
					dec.group = cod_pkg::cod_grp_branch;
				end
			endcase
		end else if (opcode < cod_pkg::cod_ops_first) begin
			dec.known = 1'b0;
		end else if (opcode == 8'h15) begin
			dec = '{1'b1, 8'h08, 2'h2, 1'b1, 1'b1, 1'b1,
				cod_pkg::cod_grp_other};
		end else if (opcode <= 8'h17 ||
				(opcode >= 8'h19 && opcode <= 8'h1f)) begin
			dec.upd_c = 1'b1;
			dec.upd_z = 1'b1;
			// the two immediate-to-memory forms carry a third byte
			dec.length = (opcode[2:1] == 2'h3) ? 2'h3 : 2'h2;
			case (opcode[2:0])
				3'h1: dec.cycles = 8'h04;
				3'h2: dec.cycles = 8'h06;
				3'h3, 3'h4: dec.cycles = 8'h07;
				3'h5: dec.cycles = 8'h08;
				3'h6: dec.cycles = 8'h09;
				default: dec.cycles = 8'h0a;
			endcase
		end else if (opcode == 8'h18 || opcode == 8'h20) begin
			dec.cycles = 8'h05;
			dec.upd_z = (opcode == 8'h18);
			dec.group = cod_pkg::cod_grp_stack;
		end else if (opcode >= 8'h21 && opcode <= 8'h2c &&
				opcode != 8'h28) begin
			dec.upd_z = 1'b1;
			dec.length = (opcode[2:1] == 2'h3) ? 2'h3 : 2'h2;
			case (opcode[2:0])
				3'h1: dec.cycles = 8'h04;
				3'h2: dec.cycles = 8'h06;
				3'h3, 3'h4: dec.cycles = 8'h07;
				3'h5: dec.cycles = 8'h08;
				3'h6: dec.cycles = 8'h09;
				default: dec.cycles = 8'h0a;
			endcase
		end else if (opcode == 8'h28) begin
			dec.cycles = 8'h0b;
			dec.upd_z = 1'b1;
		end else if (opcode >= 8'h42 && opcode <= 8'h46) begin
			dec.length = 2'h3;
			dec.upd_z = 1'b1;
			dec.cycles = opcode[0] ? 8'h09 : 8'h0a;
		end else if (opcode >= 8'h47 && opcode <= 8'h4a) begin
			dec.length = 2'h3;
			dec.upd_z = 1'b1;
			dec.cycles = (opcode == 8'h47) ? 8'h08 :
				(opcode == 8'h4a) ? 8'h0a : 8'h09;
		end else if (opcode >= 8'h4b && opcode <= 8'h4e) begin
			dec.upd_z = (opcode != 8'h4d);
			dec.cycles = (opcode == 8'h4b || opcode == 8'h4e) ? 8'h05 : 8'h07;
			dec.length = (opcode == 8'h4c || opcode == 8'h4d) ? 2'h2 : 2'h1;
		end else if (opcode >= 8'h4f && opcode <= 8'h59) begin
			dec.upd_z = (opcode >= 8'h50 && opcode <= 8'h52);
			dec.length = (opcode == 8'h55 || opcode == 8'h56) ? 2'h3 :
				(opcode == 8'h4f) ? 2'h1 : 2'h2;
			case (opcode[3:0])
				4'hf, 4'h0, 4'h7: dec.cycles = 8'h04;
				4'h1, 4'h3: dec.cycles = 8'h05;
				4'h2, 4'h4, 4'h8: dec.cycles = 8'h06;
				4'h9: dec.cycles = 8'h07;
				4'h5: dec.cycles = 8'h08;
				default: dec.cycles = 8'h09;
			endcase
		end else if (opcode >= 8'h70 && opcode <= 8'h72) begin
			dec.length = 2'h2;
			dec.upd_c = 1'b1;
			dec.upd_z = 1'b1;
			dec.group = cod_pkg::cod_grp_flagop;
		end else if (opcode == 8'h73) begin
			dec.upd_z = 1'b1;
		end else if (opcode >= 8'h74 && opcode <= 8'h7b) begin
			dec.upd_c = 1'b1;
			dec.upd_z = 1'b1;
			dec.length = opcode[1] ? 2'h2 : 2'h1;
			dec.cycles = !opcode[1] ? 8'h04 : opcode[0] ? 8'h08 : 8'h07;
		end else if (opcode == 8'h7c || opcode == 8'h7d) begin
			dec.length = 2'h3;
			dec.cycles = opcode[0] ? 8'h07 : 8'h0d;
			dec.group = opcode[0] ? cod_pkg::cod_grp_jump :
				cod_pkg::cod_grp_call;
		end else if (opcode == 8'h7e || opcode == 8'h7f) begin
			dec.cycles = opcode[0] ? 8'h08 : 8'h0a;
			dec.upd_c = !opcode[0];
			dec.upd_z = !opcode[0];
			dec.group = cod_pkg::cod_grp_return;
		end else begin
			// rows outside this table slice are reported as not known
			dec.known = 1'b0;
		end
	end

	assign end_addr = {1'b0, pc_low} + {7'h00, dec.length} - 9'h001;

	always_comb begin
		next_st = st;
		if (st.busy) begin
			next_st.count = st.count - 8'h01;
			if (st.count == 8'h01)
				next_st.busy = 1'b0;
		end else if (irq_accept) begin
			next_st.busy = 1'b1;
			next_st.count = cod_pkg::cod_irq_cycles;
			next_st.info = '{1'b1, cod_pkg::cod_irq_cycles, 2'h0, 1'b0, 1'b0,
				1'b1, cod_pkg::cod_grp_interrupt};
		end else if (start) begin
			next_st.busy = 1'b1;
			next_st.info = dec;
			// straddling a flash page costs one extra fetch cycle
			if (end_addr[8]) begin
				next_st.info.cycles = dec.cycles + cod_pkg::cod_boundary_extra;
			end
			next_st.count = next_st.info.cycles;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	assign info = st.info;
	assign busy = st.busy;
	assign done = st.busy && (st.count == 8'h01);

	// checker helpers only; the decoder itself never reads them
	assign take_op = start && !busy && !irq_accept;

	// long busy stretches are measured here, not by a long repetition
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			busy_run <= 8'h00;
		else if (busy)
			busy_run <= busy_run + 8'h01;
		else
			busy_run <= 8'h00;
	end

	default clocking cod_cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	pop_timing_a: assert property (
		take_op && opcode == 8'h18 |=> busy [*5] ##1 !busy)
		else $error("pop to accumulator not 5 cycles");
	irq_latency_a: assert property (
		irq_accept && !busy |=> ##13 (!busy && busy_run == 8'h0d))
		else $error("interrupt entry not 13 cycles");
	sub_index_a: assert property (
		take_op && opcode == 8'h15 && pc_low != 8'hff
		|=> info.cycles == 8'h08 && info.length == 2'h2 && info.upd_c)
		else $error("indexed subtract timing wrong");
	boundary_a: assert property (
		take_op && opcode == 8'h7c && pc_low == 8'hfe
		|=> info.cycles == 8'h0e)
		else $error("page crossing not charged");
	long_jump_a: assert property (
		take_op && opcode == 8'h7d && pc_low < 8'hfe
		|=> info.cycles == 8'h07 && info.length == 2'h3 && !info.upd_z)
		else $error("long jump timing wrong");
	irq_return_a: assert property (
		take_op && opcode == 8'h7e
		|=> info.cycles == 8'h0a && info.upd_c && info.upd_z)
		else $error("interrupt return decode wrong");
	branch_cycles_a: assert property (
		take_op && opcode[7:5] == 3'h5 && pc_low != 8'hff
		|=> info.cycles == 8'h05)
		else $error("conditional branch cycles wrong");
	table_read_a: assert property (
		take_op && opcode[7:4] == 4'hf && pc_low != 8'hff
		|=> info.cycles == 8'h0d && info.upd_z)
		else $error("table read decode wrong");
	complement_a: assert property (
		take_op && opcode == 8'h73
		|=> info.cycles == 8'h04 && !info.upd_c && info.upd_z)
		else $error("complement decode wrong");

	irq_cov: cover property (irq_accept && !busy);
	cross_cov: cover property (start && !busy && end_addr[8]);
	done_cov: cover property (done);
endmodule
`default_nettype wire

// ===== testbench/cod_flash.sv
`default_nettype none
module cod_flash (
	input  wire logic [12:0] addr,
	output logic      [7:0]  data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [8192];
	// xor pattern makes each low byte a distinct opcode
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = i[7:0] ^ 8'h5a;
		end
	end
	assign data = mem[addr];
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clock = 0;
	logic               rst_b = 0;
	logic               start = 0;
	logic               irq_accept = 0;
	logic [7:0]         opcode = 8'h00;
	logic [7:0]         pc_low = 8'h00;
	logic [12:0]        addr = 13'h0000;
	logic [7:0]         fdata;
	cod_pkg::cod_info_t info;
	logic               busy;
	logic               done;
	int                 fails = 0;
	int                 checks = 0;
	int                 seed = 89;
	int                 ticks = 0;

	cod_decode dut (.clock(clock), .rst_b(rst_b), .start(start),
		.opcode(opcode), .pc_low(pc_low), .irq_accept(irq_accept),
		.info(info), .busy(busy), .done(done));
	cod_flash flash (.addr(addr), .data(fdata));

	initial begin
		forever #4 clock = ~clock;
	end

	// fields: known, c, z, length, cycles
	function automatic logic [12:0] e(int c, int l, int f);
		return {1'b1, f[1:0], l[1:0], c[7:0]};
	endfunction

	function automatic logic [12:0] ref_op(logic [7:0] op);
		int t[7] = '{4, 6, 7, 7, 8, 9, 10};
		int u[10] = '{4, 5, 6, 5, 6, 8, 9, 4, 6, 7};
		case (op[7:4])
		4'h8, 4'ha, 4'hb, 4'hc, 4'hd: return e(5, 2, 0);
		4'h9: return e(11, 2, 0);
		4'he: return e(7, 2, 0);
		4'hf: return e(13, 2, 1);
		default: ;
		endcase
		if (op >= 8'h19 && op <= 8'h1f)
			return e(t[op - 8'h19], op > 8'h1d ? 3 : 2, 3);
		if (op >= 8'h21 && op <= 8'h27)
			return e(t[op - 8'h21], op > 8'h25 ? 3 : 2, 1);
		if (op >= 8'h29 && op <= 8'h2c)
			return e(t[op - 8'h29], 2, 1);
		if (op >= 8'h42 && op <= 8'h46)
			return e(op[0] ? 9 : 10, 3, 1);
		if (op >= 8'h50 && op <= 8'h59)
			return e(u[op - 8'h50], (op == 8'h55 || op == 8'h56) ? 3 : 2,
				op < 8'h53);
		if (op >= 8'h74 && op <= 8'h7b)
			return e(op[1] ? (op[0] ? 8 : 7) : 4, op[1] ? 2 : 1, 3);
		case (op)
		8'h15: return e(8, 2, 3);
		8'h16: return e(9, 3, 3);
		8'h17: return e(10, 3, 3);
		8'h18: return e(5, 1, 1);
		8'h20: return e(5, 1, 0);
		8'h28: return e(11, 1, 1);
		8'h47: return e(8, 3, 1);
		8'h48, 8'h49: return e(9, 3, 1);
		8'h4a: return e(10, 3, 1);
		8'h4b, 8'h4e: return e(5, 1, 1);
		8'h4c: return e(7, 2, 1);
		8'h4d: return e(7, 2, 0);
		8'h4f: return e(4, 1, 0);
		8'h70, 8'h71, 8'h72: return e(4, 2, 3);
		8'h73: return e(4, 1, 1);
		8'h7c: return e(13, 3, 0);
		8'h7d: return e(7, 3, 0);
		8'h7e: return e(10, 1, 3);
		8'h7f: return e(8, 1, 0);
		default: return {1'b0, 2'h0, 2'h1, 8'h04};
		endcase
	endfunction

	task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// requests raised while busy must be ignored
	task automatic run(logic irq, logic [7:0] op, logic [7:0] pc);
		logic [12:0] x;
		int n;
		int c;
		logic d;
		x = ref_op(op);
		c = irq ? 13 : x[7:0] + ((pc + x[9:8] - 1 > 255) ? 1 : 0);
		@(posedge clock);
		#1;
		start = 1;
		opcode = op;
		pc_low = pc;
		irq_accept = irq;
		@(posedge clock);
		#1;
		start = 0;
		irq_accept = 0;
		n = 0;
		d = 0;
		while (busy === 1'b1 && n < 300) begin
			d = done;
			start = (n == 2);
			irq_accept = (n == 3);
			@(posedge clock);
			#1;
			n++;
		end
		start = 0;
		irq_accept = 0;
		chk("busy length", n[7:0], c[7:0]);
		chk("last done", {7'h0, d}, 8'h01);
		chk("valid", {7'h0, info.valid}, 8'h01);
		if (!irq) begin
			chk("cycles", info.cycles, c[7:0]);
			chk("length", {6'h0, info.length}, {6'h0, x[9:8]});
			chk("flags", {6'h0, info.upd_c, info.upd_z},
				{6'h0, x[11:10]});
			chk("known", {7'h0, info.known}, {7'h0, x[12]});
		end else begin
			chk("irq group", {5'h0, info.group},
				{5'h0, cod_pkg::cod_grp_interrupt});
		end
	endtask

	always @(posedge clock) begin
		ticks++;
		if (ticks == 20000) begin
			fails++;
			finish_test();
		end
	end

	initial begin
		repeat (10) @(posedge clock);
		#1 rst_b = 1;
		for (int i = 0; i < 256; i++) begin
			addr = i[12:0];
			#1 run(0, fdata, addr[7:0]);
		end
		run(0, 8'h7c, 8'hfe);
		run(0, 8'h7c, 8'hfd);
		repeat (40) begin
			addr = 13'($random(seed));
			#1 run(addr[8], fdata, addr[7:0]);
		end
		finish_test();
	end
endmodule
`default_nettype wire
